// ---- dv/mpd_gate_drv.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Gate driver model of one motor bridge: four legs, high and low switch
module mpd_gate_drv (
    input wire logic i_clock,
    input wire logic [3:0] i_high,
    input wire logic [3:0] i_low,
    output logic [7:0] o_shoot_cnt
);
    logic [7:0] shoot_r = 8'h00;
    // Counts cycles in which a leg would conduct through both switches
    always @(posedge i_clock) begin
        if ((i_high & i_low) != 4'h0) begin
            shoot_r <= shoot_r + 8'h01;
        end
    end
    assign o_shoot_cnt = shoot_r;
endmodule : mpd_gate_drv
`default_nettype wire

// ---- dv/mpd_pwm_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bus handshake and output safety checks at the block ports
module mpd_pwm_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire mpd_pkg::mpd_tb_t i_tb,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    input wire logic i_awvalid,
    input wire logic i_wvalid,
    input wire logic i_bready,
    input wire logic o_awready,
    input wire logic o_wready,
    input wire logic o_arready,
    input wire logic o_bvalid,
    input wire logic o_rvalid,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic [3:0] o_pair_high_output,
    input wire logic [3:0] o_pair_low_output
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    a_no_shoot_through: assert property (
        (o_pair_high_output & o_pair_low_output) == 4'h0) else $error("pair both high");
    a_write_busy: assert property (
        o_bvalid |-> !o_awready && !o_wready) else $error("write taken while answering");
    a_write_answer: assert property (
        i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
        else $error("write answer late");
    a_write_ready_back: assert property (
        o_bvalid && i_bready |=> o_awready && o_wready) else $error("write ready missing");
    a_read_busy: assert property (
        o_rvalid |-> !o_arready) else $error("read taken while answering");
    a_read_answer: assert property (
        i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
    a_status_direction: assert property (
        i_arvalid && o_arready && i_araddr == mpd_pkg::MPD_OFS_STATUS |=>
        o_rdata == {16'h0, $past(i_tb.count_direction), $past(i_tb.time_base_counter)})
        else $error("status read wrong");
    a_unmapped_read: assert property (
        i_arvalid && o_arready && i_araddr == 8'h28 |=>
        o_rresp == mpd_pkg::MPD_RESP_SLVERR && o_rdata == 32'h0) else $error("unmapped read");
endmodule : mpd_pwm_checker
bind mpd_pwm mpd_pwm_checker #(.ADDR_W(ADDR_W)) i_mpd_pwm_checker (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_tb(i_tb), .i_araddr(i_araddr),
    .i_arvalid(i_arvalid), .i_awvalid(i_awvalid), .i_wvalid(i_wvalid), .i_bready(i_bready),
    .o_awready(o_awready), .o_wready(o_wready), .o_arready(o_arready), .o_bvalid(o_bvalid),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_pair_high_output(o_pair_high_output), .o_pair_low_output(o_pair_low_output)
);
`default_nettype wire

// ---- dv/mpd_pwm_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Self-checking bench: registers, compare modes and dead time
module mpd_pwm_tb;
    localparam int P = 40;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, dn = 1'b0;
    logic [1:0] md = 2'h0, bres, rres, bres_o, rres_o;
    logic [14:0] cnt = 15'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, shoot;
    logic [31:0] wdata = 32'h0, rdat, rdata_o;
    logic awv = 1'b0, wv = 1'b0, arv = 1'b0, awr, wr_rdy, bv, arr, rv;
    logic [15:0] du [4];
    logic [3:0] hi, lo;
    int error_cnt = 0, n_compared = 0;
    wire mpd_pkg::mpd_tb_t tbv = {en, md, dn, cnt};
    always #5 clk = ~clk;
    mpd_pwm i_mpd_pwm (
        .i_clock(clk), .i_rst_n(rst_n), .i_tb(tbv), .i_awaddr(awaddr), .i_awvalid(awv),
        .o_awready(awr), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wr_rdy),
        .o_bresp(bres_o), .o_bvalid(bv), .i_bready(1'b1), .i_araddr(araddr), .i_arvalid(arv),
        .o_arready(arr), .o_rdata(rdata_o), .o_rresp(rres_o), .o_rvalid(rv), .i_rready(1'b1),
        .o_pair_high_output(hi), .o_pair_low_output(lo)
    );
    mpd_gate_drv i_mpd_gate_drv (.i_clock(clk), .i_high(hi), .i_low(lo), .o_shoot_cnt(shoot));
    // External time base: sawtooth in edge modes, triangle in up/down modes
    always @(posedge clk) begin
        if (!en) begin
            cnt <= 15'h0;
            dn <= 1'b0;
        end else if (!md[1]) begin
            cnt <= (cnt == P) ? 15'h0 : cnt + 15'h1;
        end else if (dn) begin
            cnt <= cnt - 15'h1;
            dn <= (cnt != 15'h1);
        end else begin
            cnt <= (cnt == P) ? cnt - 15'h1 : cnt + 15'h1;
            dn <= (cnt == P);
        end
    end
    // ==========================================================
    // Bus cycles, comparison and expectation helpers
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr === 1'b1) awv <= 1'b0;
            if (wv && wr_rdy === 1'b1) wv <= 1'b0;
        end while (awv || wv);
        do @(posedge clk); while (bv !== 1'b1);
        bres = bres_o;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arv <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rdat = rdata_o;
        rres = rres_o;
    endtask : rd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic int exp_hi(logic [15:0] d);
        if (!md[1]) return (d > P) ? P + 1 : d[15:1] + d[0];
        return (d == P) ? 2 * P : 2 * d[15:1];
    endfunction : exp_hi
    function automatic logic [15:0] pick(int p, logic [1:0] m);
        logic [15:0] r;
        r = 16'($urandom_range(1, P - 1) * 2);
        if (m[1] && r == P) r = r + 16'h2;
        case (p)
            0: return 16'h0;
            1: return m[1] ? 16'(P) : 16'hffff;
            3: return m[1] ? r : r + 16'h1;
            default: return r;
        endcase
    endfunction : pick
    // Counts high and low cycles of every pair over one full PWM period
    task automatic run_check(input int len, input int dh, input int dl);
        int h [4];
        int l [4];
        int e;
        repeat (2) begin
            do @(posedge clk); while (!(cnt == 15'h0 && !dn));
        end
        h = '{default: 0};
        l = '{default: 0};
        repeat (len) begin
            @(posedge clk);
            for (int p = 0; p < 4; p++) begin
                h[p] += int'(hi[p] === 1'b1);
                l[p] += int'(lo[p] === 1'b1);
            end
        end
        for (int p = 0; p < 4; p++) begin
            e = exp_hi(du[p]);
            if (e == 0 || e == len) begin
                dh = 0;
                dl = 0;
            end
            chk(32'(h[p]), 32'(e - dh));
            chk(32'(l[p]), 32'(len - e - dl));
        end
    endtask : run_check
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    // Watchdog against a hung handshake
    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end
    // ==========================================================
    // Test sequence
    initial begin
        int idx;
        logic [31:0] v;
        void'($urandom(53));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        for (int a = 0; a <= 36; a += 4) begin
            rd(8'(a));
            chk(rdat, 32'h0);
            chk(rres, mpd_pkg::MPD_RESP_OKAY);
        end
        $display("test reset_values done");
        wr(mpd_pkg::MPD_OFS_OUTCTL2, 32'h1);
        wr(mpd_pkg::MPD_OFS_DUTY1, 32'h14);
        repeat (5) @(posedge clk);
        chk(hi[0], 1'b0);
        wr(mpd_pkg::MPD_OFS_OUTCTL2, 32'h0);
        repeat (5) @(posedge clk);
        chk(hi[0], 1'b1);
        chk(lo[0], 1'b0);
        $display("test idle_copy done");
        repeat (6) begin
            idx = $urandom_range(0, 4);
            v = $urandom;
            wr(8'(4 * idx), v);
            chk(bres, mpd_pkg::MPD_RESP_OKAY);
            rd(8'(4 * idx));
            chk(rdat, v & ((idx == 0) ? 32'h7fff : 32'hffff));
        end
        wr(8'h28, 32'h1234);
        chk(bres, mpd_pkg::MPD_RESP_SLVERR);
        rd(8'h28);
        chk(rres, mpd_pkg::MPD_RESP_SLVERR);
        wr(mpd_pkg::MPD_OFS_STATUS, 32'hffff);
        rd(mpd_pkg::MPD_OFS_STATUS);
        chk(rdat, 32'h0);
        $display("test register_access done");
        wr(mpd_pkg::MPD_OFS_PERIOD, 32'(P));
        for (int m = 0; m < 4; m++) begin
            md <= 2'(m);
            for (int pass = 0; pass < 2; pass++) begin
                for (int p = 0; p < 4; p++) begin
                    du[p] = pick(p, 2'(m));
                    wr(8'(4 + 4 * p), 32'(du[p]));
                end
                en <= 1'b1;
                run_check(m > 1 ? 2 * P : P + 1, 0, 0);
            end
            rd(mpd_pkg::MPD_OFS_STATUS);
            en <= 1'b0;
            $display("test mode %0d done", m);
        end
        md <= mpd_pkg::MPD_MODE_FREE;
        for (int p = 0; p < 4; p++) begin
            du[p] = 16'h28;
            wr(8'(4 + 4 * p), 32'h28);
        end
        wr(mpd_pkg::MPD_OFS_DTCTL1, 32'h4203);
        for (int c = 0; c < 2; c++) begin
            wr(mpd_pkg::MPD_OFS_DTCTL2, c ? 32'hf0 : 32'h0f);
            en <= 1'b1;
            run_check(P + 1, c ? 3 : 4, c ? 4 : 3);
            en <= 1'b0;
        end
        $display("test dead_time done");
        chk(shoot, 8'h0);
        give_verdict();
    end
endmodule : mpd_pwm_tb
`default_nettype wire

// ---- hw/mpd_pkg.sv ----
// Functional notes
// RULE1: Period buffer loads active period when counter wraps to zero in edge modes.
// RULE2: In up/down modes the period buffer loads whenever the counter is zero.
// RULE3: While the time base is disabled the period buffer copies continuously.
// RULE4: PWM period is cycle time times (period+1) times prescale; doubled up/down.
// RULE5: Edge-aligned output goes active at counter zero, inactive on duty match.
// RULE6: Edge-aligned: duty zero never active; duty above period always active.
// RULE7: Center-aligned: active on match counting down, inactive on match counting up.
// RULE8: Center-aligned: duty zero never active; duty equal to period always active.
// RULE9: Four 16-bit duty registers, one per duty generator, set active time.
// RULE10: Duty LSB delays the edge by half a count, doubling resolution.
// RULE11: Each duty has buffer and active copy; edge modes load at period wrap.
// RULE12: Edge modes copy duties while disabled and update disable is clear.
// RULE13: Single-update up/down loads duties at zero going up, and while disabled.
// RULE14: Double-update mode loads duties at zero, at period match, and while disabled.
// RULE15: Duty n drives pair n; low output complements high with optional dead time.
// RULE16: Pair is complementary when its mode bit is clear; reset default complementary.
// RULE17: Two dead times, one per switching direction, independently programmable.
// RULE18: Each pair has a 6-bit down counter loaded on compare rising and falling edges.
// RULE19: Per pair, one bit picks active-edge dead time, another the inactive-edge one.
// RULE20: Each dead time has a 2-bit prescale: one, two, four or eight cycles.
// RULE21: Both 6-bit dead time counts live in dead time control one.
// RULE22: Dead time prescalers clear on counter load, control writes and reset.
// RULE23: Counter status bit 15 reads count direction, 0 up, 1 down, read only.
// RULE24: Mode 00 free-running, 01 single-shot, 10 up/down, 11 up/down double update.
// RULE25: Nonzero dead time counter holds both pair outputs inactive; pairs with the mode bit set ignore the counter here.
// RULE26: Software should not change dead time controls while time base runs.
package mpd_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] MPD_OFS_PERIOD = 8'h00;
    localparam logic [7:0] MPD_OFS_DUTY1 = 8'h04;
    localparam logic [7:0] MPD_OFS_OUTCTL1 = 8'h14;
    localparam logic [7:0] MPD_OFS_OUTCTL2 = 8'h18;
    localparam logic [7:0] MPD_OFS_DTCTL1 = 8'h1c;
    localparam logic [7:0] MPD_OFS_DTCTL2 = 8'h20;
    localparam logic [7:0] MPD_OFS_STATUS = 8'h24;
    // ==========================================================
    // Field positions
    localparam int MPD_DT_A_LSB = 0;
    localparam int MPD_DT_A_PS_LSB = 6;
    localparam int MPD_DT_B_LSB = 8;
    localparam int MPD_DT_B_PS_LSB = 14;
    localparam int MPD_UPDATE_DISABLE_BIT = 0;
    localparam int MPD_DIR_BIT = 15;
    // ==========================================================
    // Time base modes
    localparam logic [1:0] MPD_MODE_FREE = 2'h0;
    localparam logic [1:0] MPD_MODE_SHOT = 2'h1;
    localparam logic [1:0] MPD_MODE_UPDN = 2'h2;
    localparam logic [1:0] MPD_MODE_UPDN2 = 2'h3;
    // ==========================================================
    // Reset values and bus answers
    localparam logic [15:0] MPD_RST_REG = 16'h0000;
    localparam logic [1:0] MPD_RESP_OKAY = 2'h0;
    localparam logic [1:0] MPD_RESP_SLVERR = 2'h2;
    localparam int MPD_PAIRS = 4;

    // Time base inputs shared from the counter block
    typedef struct packed {
        logic time_base_enable;
        logic [1:0] time_base_mode;
        logic count_direction;
        logic [14:0] time_base_counter;
    } mpd_tb_t;

    // Whole state of the PWM compare and dead time block
    typedef struct packed {
        logic [14:0] per_buf;
        logic [14:0] per_act;
        logic [3:0][15:0] duty_buf;
        logic [3:0][15:0] duty_act;
        logic [3:0] pair_mode_select;
        logic update_disable;
        logic [15:0] dtc1;
        logic [7:0] dtc2;
        logic [14:0] prev_cnt;
        logic [3:0] raw;
        logic [3:0] cmp;
        logic [3:0][5:0] dt_cnt;
        logic [3:0] dt_unit;
        logic [2:0] pre_a;
        logic [2:0] pre_b;
        logic [3:0] out_h;
        logic [3:0] out_l;
        logic awv;
        logic [7:0] awaddr;
        logic wv;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awrdy;
        logic wrdy;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mpd_state_t;
endpackage : mpd_pkg

// ---- hw/mpd_pwm.sv ----
`timescale 1ns/1ns
`default_nettype none
// PWM compare, duty double buffering and dead time stage for four pairs
module mpd_pwm #(
    parameter int ADDR_W = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire mpd_pkg::mpd_tb_t i_tb,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [3:0] o_pair_high_output,
    output logic [3:0] o_pair_low_output
);
    // ==========================================================
    // Reset release
    logic rst_meta_r;
    logic rst_sync_r;
    mpd_pkg::mpd_state_t s_r;
    mpd_pkg::mpd_state_t s_nxt;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ==========================================================
    // Helpers
    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0]) r[7:0] = d[7:0];
        if (st[1]) r[15:8] = d[15:8];
        return r;
    endfunction : merge16

    // Last prescaler count for a 2-bit select: 1, 2, 4 or 8 cycles
    function automatic logic [2:0] ps_last(input logic [1:0] ps);
        logic [2:0] r;
        unique case (ps)
            2'h0: r = 3'h0;
            2'h1: r = 3'h1;
            2'h2: r = 3'h3;
            2'h3: r = 3'h7;
        endcase
        return r;
    endfunction : ps_last

    // ==========================================================
    // Decoded combinational terms
    logic [7:0] wa;
    logic [7:0] ra;
    logic do_wr;
    logic wr_ok;
    logic rd_ok;
    logic dt_wr;
    logic edge_mode;
    logic at_zero;
    logic wrap;
    logic per_load;
    logic duty_load;
    logic tick_a;
    logic tick_b;
    logic load_any;
    logic [14:0] dh;
    logic c;
    logic rise;
    logic fall;
    logic sel;
    logic tk;
    logic [31:0] rd;
    logic [15:0] pm;

    // Next-state logic of the whole block
    always_comb begin
        s_nxt = s_r;
        wa = {s_r.awaddr[7:2], 2'h0};
        ra = 8'(i_araddr);
        ra = {ra[7:2], 2'h0};
        do_wr = s_r.awv && s_r.wv && !s_r.bvalid;
        wr_ok = 1'b0;
        rd_ok = 1'b0;
        dt_wr = 1'b0;
        load_any = 1'b0;
        dh = 15'h0000;
        c = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        sel = 1'b0;
        tk = 1'b0;
        rd = 32'h0000_0000;
        pm = 16'h0000;

        // Write address and data are taken independently
        if (i_awvalid && s_r.awrdy) begin
            s_nxt.awv = 1'b1;
            s_nxt.awaddr = 8'(i_awaddr);
        end
        if (i_wvalid && s_r.wrdy) begin
            s_nxt.wv = 1'b1;
            s_nxt.wdata = i_wdata;
            s_nxt.wstrb = i_wstrb;
        end

        // Period and duty writes go to the software-visible buffers; control registers take writes directly
        if (do_wr) begin
            wr_ok = 1'b1;
            if (wa == mpd_pkg::MPD_OFS_PERIOD) begin
                pm = merge16({1'b0, s_r.per_buf}, s_r.wdata, s_r.wstrb);
                s_nxt.per_buf = pm[14:0]; // RULE1
            end else if (wa == mpd_pkg::MPD_OFS_OUTCTL1) begin
                if (s_r.wstrb[0]) s_nxt.pair_mode_select = s_r.wdata[3:0]; // RULE16
            end else if (wa == mpd_pkg::MPD_OFS_OUTCTL2) begin
                if (s_r.wstrb[0]) s_nxt.update_disable = s_r.wdata[mpd_pkg::MPD_UPDATE_DISABLE_BIT];
            end else if (wa == mpd_pkg::MPD_OFS_DTCTL1) begin
                s_nxt.dtc1 = merge16(s_r.dtc1, s_r.wdata, s_r.wstrb); // RULE21
                dt_wr = 1'b1;
            end else if (wa == mpd_pkg::MPD_OFS_DTCTL2) begin
                if (s_r.wstrb[0]) s_nxt.dtc2 = s_r.wdata[7:0]; // RULE19
                dt_wr = 1'b1;
            end else if (wa == mpd_pkg::MPD_OFS_STATUS) begin
                wr_ok = 1'b1;
            end else begin
                wr_ok = 1'b0;
            end
            for (int i = 0; i < mpd_pkg::MPD_PAIRS; i++) begin
                if (wa == 8'(mpd_pkg::MPD_OFS_DUTY1 + 8'(4 * i))) begin
                    s_nxt.duty_buf[i] = merge16(s_r.duty_buf[i], s_r.wdata, s_r.wstrb); // RULE9
                    wr_ok = 1'b1;
                end
            end
            s_nxt.awv = 1'b0;
            s_nxt.wv = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = wr_ok ? mpd_pkg::MPD_RESP_OKAY : mpd_pkg::MPD_RESP_SLVERR;
        end
        if (s_r.bvalid && i_bready) s_nxt.bvalid = 1'b0;
        // Readies stay low while an item is held or the response is pending
        s_nxt.awrdy = !s_nxt.awv && !s_nxt.bvalid;
        s_nxt.wrdy = !s_nxt.wv && !s_nxt.bvalid;

        // Read answers one cycle after the address is taken
        if (i_arvalid && s_r.arrdy) begin
            rd_ok = 1'b1;
            if (ra == mpd_pkg::MPD_OFS_PERIOD) begin
                rd = {17'h00000, s_r.per_buf};
            end else if (ra == mpd_pkg::MPD_OFS_OUTCTL1) begin
                rd = {28'h0000000, s_r.pair_mode_select};
            end else if (ra == mpd_pkg::MPD_OFS_OUTCTL2) begin
                rd = {31'h00000000, s_r.update_disable};
            end else if (ra == mpd_pkg::MPD_OFS_DTCTL1) begin
                rd = {16'h0000, s_r.dtc1};
            end else if (ra == mpd_pkg::MPD_OFS_DTCTL2) begin
                rd = {24'h000000, s_r.dtc2};
            end else if (ra == mpd_pkg::MPD_OFS_STATUS) begin
                rd = {16'h0000, i_tb.count_direction, i_tb.time_base_counter}; // RULE23
            end else begin
                rd_ok = 1'b0;
            end
            for (int i = 0; i < mpd_pkg::MPD_PAIRS; i++) begin
                if (ra == 8'(mpd_pkg::MPD_OFS_DUTY1 + 8'(4 * i))) begin
                    rd = {16'h0000, s_r.duty_buf[i]};
                    rd_ok = 1'b1;
                end
            end
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd;
            s_nxt.rresp = rd_ok ? mpd_pkg::MPD_RESP_OKAY : mpd_pkg::MPD_RESP_SLVERR;
        end
        if (s_r.rvalid && i_rready) s_nxt.rvalid = 1'b0;
        s_nxt.arrdy = !s_nxt.rvalid;

        // Reload points of the time base
        edge_mode = !i_tb.time_base_mode[1]; // RULE24
        at_zero = i_tb.time_base_counter == 15'h0000;
        wrap = at_zero && s_r.prev_cnt == s_r.per_act; // RULE4
        s_nxt.prev_cnt = i_tb.time_base_counter;
        if (!i_tb.time_base_enable) begin
            per_load = 1'b1; // RULE3
        end else if (edge_mode) begin
            per_load = wrap; // RULE1
        end else begin
            per_load = at_zero; // RULE2
        end
        if (per_load) s_nxt.per_act = s_r.per_buf;

        // Duty reload depends on mode; update disable gates only the edge-mode idle copy
        unique case (i_tb.time_base_mode)
            mpd_pkg::MPD_MODE_FREE, mpd_pkg::MPD_MODE_SHOT: begin
                duty_load = i_tb.time_base_enable ? wrap : !s_r.update_disable; // RULE11 RULE12
            end
            mpd_pkg::MPD_MODE_UPDN: begin
                duty_load = !i_tb.time_base_enable
                    || (at_zero && !i_tb.count_direction); // RULE13
            end
            mpd_pkg::MPD_MODE_UPDN2: begin
                duty_load = !i_tb.time_base_enable || at_zero
                    || i_tb.time_base_counter == s_r.per_act; // RULE14
            end
        endcase
        if (duty_load) s_nxt.duty_act = s_r.duty_buf;

        // Dead time prescaler ticks from the present counts
        tick_a = s_r.pre_a == ps_last(s_r.dtc1[mpd_pkg::MPD_DT_A_PS_LSB +: 2]); // RULE20
        tick_b = s_r.pre_b == ps_last(s_r.dtc1[mpd_pkg::MPD_DT_B_PS_LSB +: 2]); // RULE20

        // Per pair: compare, edge detect, dead time count and outputs
        for (int i = 0; i < mpd_pkg::MPD_PAIRS; i++) begin
            dh = s_r.duty_act[i][15:1];
            if (s_r.duty_act[i] == 16'h0000) begin
                s_nxt.raw[i] = 1'b0; // RULE6 RULE8
            end else if (edge_mode) begin
                // Duty register above the period keeps the output active
                s_nxt.raw[i] = (i_tb.time_base_counter < dh)
                    || s_r.duty_act[i] > {1'b0, s_r.per_act}; // RULE5 RULE6
            end else if (dh >= s_r.per_act || s_r.duty_act[i] == {1'b0, s_r.per_act}) begin
                s_nxt.raw[i] = 1'b1; // RULE8
            end else begin
                s_nxt.raw[i] = (i_tb.time_base_counter < dh)
                    || (i_tb.time_base_counter == dh && i_tb.count_direction); // RULE7
            end
            c = s_nxt.raw[i] || (s_r.duty_act[i][0] && s_r.raw[i]); // RULE10
            s_nxt.cmp[i] = c;
            rise = c && !s_r.cmp[i];
            fall = !c && s_r.cmp[i];
            sel = rise ? s_r.dtc2[i] : s_r.dtc2[4 + i];
            tk = s_r.dt_unit[i] ? tick_b : tick_a;
            if (rise || fall) begin
                s_nxt.dt_cnt[i] = sel ? s_r.dtc1[mpd_pkg::MPD_DT_B_LSB +: 6]
                                      : s_r.dtc1[mpd_pkg::MPD_DT_A_LSB +: 6]; // RULE18 RULE17
                s_nxt.dt_unit[i] = sel; // RULE19
                load_any = 1'b1;
            end else if (s_r.dt_cnt[i] != 6'h00 && tk) begin
                s_nxt.dt_cnt[i] = s_r.dt_cnt[i] - 6'h01;
            end
            if (s_r.pair_mode_select[i]) begin
                s_nxt.out_h[i] = c;
                s_nxt.out_l[i] = c;
            end else begin
                s_nxt.out_h[i] = c && s_nxt.dt_cnt[i] == 6'h00; // RULE15 RULE25
                s_nxt.out_l[i] = !c && s_nxt.dt_cnt[i] == 6'h00; // RULE15 RULE25
            end
        end

        // Prescalers run freely and clear on loads and control writes
        s_nxt.pre_a = tick_a ? 3'h0 : s_r.pre_a + 3'h1;
        s_nxt.pre_b = tick_b ? 3'h0 : s_r.pre_b + 3'h1;
        if (load_any || dt_wr) begin
            s_nxt.pre_a = 3'h0; // RULE22
            s_nxt.pre_b = 3'h0; // RULE22
        end
    end

    // State register; reset clears everything, pairs complementary
    always_ff @(posedge i_clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            s_r <= '0; // RULE16 RULE22
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs straight from the state register
    assign o_awready = s_r.awrdy;
    assign o_wready = s_r.wrdy;
    assign o_bvalid = s_r.bvalid;
    assign o_bresp = s_r.bresp;
    assign o_arready = s_r.arrdy;
    assign o_rvalid = s_r.rvalid;
    assign o_rdata = s_r.rdata;
    assign o_rresp = s_r.rresp;
    assign o_pair_high_output = s_r.out_h;
    assign o_pair_low_output = s_r.out_l;
endmodule : mpd_pwm
`default_nettype wire
